// [core/mrs_pkg.sv]
// Package of constants shared by both ends of the mode-register link.
package mrs_pkg;
    // ------------------------------------------------------------------
    // Command encodings {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_WR    = 4'h4;
    localparam logic [3:0] CMD_RD    = 4'h5;
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_DESEL = 4'h8;
    // ------------------------------------------------------------------
    // Bank address selection of the mode registers
    // ------------------------------------------------------------------
    localparam logic [1:0] BA_MR  = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam logic [1:0] BA_EMR3 = 2'h3;
    // ------------------------------------------------------------------
    // Main mode register field positions
    // ------------------------------------------------------------------
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int MR_WR_LSB = 9;
    localparam logic [2:0] BL_CODE4 = 3'h2;
    localparam logic [2:0] BL_CODE8 = 3'h3;
    // ------------------------------------------------------------------
    // Extended register 1 field positions
    // ------------------------------------------------------------------
    localparam int EMR1_DLLDIS_BIT = 0;
    localparam int EMR1_RDS_BIT    = 1;
    localparam int EMR1_RTT0_BIT   = 2;
    localparam int EMR1_AL_LSB     = 3;
    localparam int EMR1_RTT1_BIT   = 6;
    localparam int EMR1_OCD_LSB    = 7;
    localparam int EMR1_DQSN_BIT   = 10;
    localparam logic [2:0] OCD_EXIT    = 3'h0;
    localparam logic [2:0] OCD_DEFAULT = 3'h7;
    // ------------------------------------------------------------------
    // Timing, in their own units and in cycles of the 10 ns pclk
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_POWERUP_US  = 200;
    localparam int T_CKEWAIT_NS  = 400;
    localparam int POWERUP_CYC   = (T_POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKEWAIT_CYC   = (T_CKEWAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLL_LOCK_CYC  = 200;
    localparam int MRD_CYC       = 2;
    localparam int RP_CYC        = 2;
    localparam int RFC_CYC       = 11;
    localparam int MIN_REFRESH   = 2;
    // ------------------------------------------------------------------
    // Software register map of the controller (APB, byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MR     = 12'h008;
    localparam logic [11:0] ADDR_EMR1   = 12'h00c;
    localparam logic [11:0] ADDR_EMR2   = 12'h010;
    localparam logic [11:0] ADDR_EMR3   = 12'h014;
    localparam logic [11:0] ADDR_DEVMR  = 12'h018;
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_SKIPRST_BIT = 1;
    localparam logic [12:0] MR_RESET   = 13'h0632;
    localparam logic [12:0] EMR1_RESET = 13'h0000;
endpackage : mrs_pkg

// [core/mrs_link_if.sv]
// Interface joining the controller and the mode-register device end.
`timescale 1ns/1ps
`default_nettype none
interface mrs_link_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic        odt;
    logic        dm;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm);
    modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm);
endinterface : mrs_link_if
`default_nettype wire

// [core/mrs_device.sv]
// Device end: mode-register decode, power states and burst ordering.
`timescale 1ns/1ps
`default_nettype none
module mrs_device
    import mrs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    mrs_link_if.dev          link,
    input  wire logic [2:0]  burst_start,
    input  wire logic [2:0]  beat_index,
    output logic [12:0]      mr,
    output logic [12:0]      emr1,
    output logic [12:0]      emr2,
    output logic [12:0]      emr3,
    output logic [2:0]       burst_col,
    output logic             powered_down,
    output logic             self_refresh,
    output logic             dll_locked,
    output logic             cfg_error,
    output logic             beat_masked
);
    // ------------------------------------------------------------------
    // Command decode; odt takes no part in it.
    // ------------------------------------------------------------------
    logic [3:0] cmd;
    logic       cke_prev;
    logic [7:0] dll_cnt;
    logic       cmd_valid;
    logic       is_mrs;
    logic       is_ref;
    logic [2:0] next_col;
    logic       code_bad;
    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign cmd_valid = cke_prev && link.cke && !self_refresh;
    assign is_mrs = cmd_valid && (cmd == CMD_MRS);
    assign is_ref = cmd_valid && (cmd == CMD_REF);
    // Reserved burst length, test mode, latency and recovery codes.
    assign code_bad = (link.addr[MR_BL_LSB +: 3] != BL_CODE4 && link.addr[MR_BL_LSB +: 3] != BL_CODE8)
                    || link.addr[MR_TM_BIT]
                    || link.addr[MR_CL_LSB +: 3] < 3'h3
                    || link.addr[MR_WR_LSB +: 3] == 3'h0;
    // Sequential wraps in a group of four; interleave XORs in the index.
    assign next_col = mr[MR_BT_BIT] ? (burst_start ^ beat_index)
        : {burst_start[2] ^ beat_index[2], 2'(burst_start[1:0] + beat_index[1:0])};

    // ------------------------------------------------------------------
    // Mode registers, selected by the bank address.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr   <= 13'h0000;
            emr1 <= 13'h0000;
            emr2 <= 13'h0000;
            emr3 <= 13'h0000;
        end else if (is_mrs) begin
            case (link.ba)
                BA_MR:   mr   <= link.addr;
                BA_EMR1: emr1 <= link.addr;
                BA_EMR2: emr2 <= link.addr;
                default: emr3 <= link.addr;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power states: one clock after cke changes, no refresh while down.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke_prev     <= 1'b0;
            powered_down <= 1'b0;
            self_refresh <= 1'b0;
            cfg_error    <= 1'b0;
        end else begin
            cke_prev <= link.cke;
            if (cke_prev && !link.cke) begin
                self_refresh <= (cmd == CMD_REF);
                powered_down <= (cmd != CMD_REF);
            end else if (!cke_prev && link.cke) begin
                self_refresh <= 1'b0;
                powered_down <= 1'b0;
            end
            if (is_mrs && link.ba == BA_MR && code_bad)
                cfg_error <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // DLL lock counter; enable or reset or self-refresh exit restarts it.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_cnt    <= 8'h00;
            dll_locked <= 1'b0;
        end else if ((is_mrs && link.ba == BA_EMR1 && !link.addr[EMR1_DLLDIS_BIT])
                  || (is_mrs && link.ba == BA_MR && link.addr[MR_DLLRST_BIT])
                  || (self_refresh && !cke_prev && link.cke)) begin
            dll_cnt    <= 8'h00;
            dll_locked <= 1'b0;
        end else if (emr1[EMR1_DLLDIS_BIT]) begin
            dll_locked <= 1'b0;
        end else if (dll_cnt != 8'(DLL_LOCK_CYC - 1)) begin
            dll_cnt <= dll_cnt + 8'h01;
        end else begin
            dll_locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Burst column and write masking; a burst is never cut short.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_col   <= 3'h0;
            beat_masked <= 1'b0;
        end else begin
            burst_col   <= next_col;
            beat_masked <= link.dm;
        end
    end
    // Refresh needs no state here; is_ref only marks legality.
    logic unused_ref;
    assign unused_ref = is_ref ^ link.odt;
endmodule : mrs_device
`default_nettype wire

// [core/mrs_ctrl.sv]
// Controller end: APB registers and the power-up mode-register sequence.
// --------------------------------------------------------------------
// Notes on behaviour
// - Bank address picks the target mode register.
// - Mode set only with all banks precharged.
// - Length-four bursts are never interrupted.
// - No refresh in power-down; one-clock entry/exit.
// - ODT ignored in self refresh.
// - Only NOP after self-refresh exit interval.
// - Self refresh only from all banks idle.
// - No power-down during busy operations.
// - CKE high in calibration; minimum CKE times.
// - ODT held defined during power-down.
// - Data mask accompanies and masks write beats.
// - Hold CKE/ODT low 200us, then raise CKE.
// - Wait 400ns on NOP, then precharge all.
// - Program extended 2, 3, then 1 with DLL.
// - DLL reset, precharge, two refreshes, mode set.
// - After 200 clocks, calibration default then exit.
// - DLL reset step skippable with 200 extra clocks; skip_rst skips S_MRRST and adds no clocks to the S_DLLW wait.
// - Main register field layout as defined.
// - All-low command loads main register.
// - Write recovery equals recovery time over period.
// - Burst order sequential or interleaved.
// - Wait 200 clocks after DLL enable before read.
// - Extended register 1 field layout.
// --------------------------------------------------------------------
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mrs_ctrl
    import mrs_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    mrs_link_if.ctrl         link
);
    typedef enum {S_IDLE, S_PWR, S_CKEW, S_PRE1, S_EMR2, S_EMR3, S_EMR1, S_MRRST,
                  S_PRE2, S_REF, S_MR, S_DLLW, S_OCDDEF, S_OCDEXIT, S_READY} state_t;
    state_t      state;
    state_t      next_state;
    logic [31:0] cnt;
    logic [1:0]  refs;
    logic [12:0] mr;
    logic [12:0] emr1;
    logic [12:0] emr2;
    logic [12:0] emr3;
    logic        skip_rst;
    logic        start;
    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    wire access   = psel && penable;
    wire wr_en    = access && pwrite;
    wire hit      = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_MR
                 || paddr == ADDR_EMR1 || paddr == ADDR_EMR2 || paddr == ADDR_EMR3;
    wire [31:0] rd_mux =
        paddr == ADDR_CTRL   ? {30'h0, skip_rst, start} :
        paddr == ADDR_STATUS ? {27'h0, 5'(state)} :
        paddr == ADDR_MR     ? {19'h0, mr} :
        paddr == ADDR_EMR1   ? {19'h0, emr1} :
        paddr == ADDR_EMR2   ? {19'h0, emr2} :
        paddr == ADDR_EMR3   ? {19'h0, emr3} : 32'h0;
    wire wait_done = cnt == 32'h0;
    wire go        = start && state == S_IDLE;

    // Zero-wait-state APB slave: answers in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Software-written settings; start self-clears once the sequence begins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start    <= 1'b0;
            skip_rst <= 1'b0;
            mr       <= MR_RESET;
            emr1     <= EMR1_RESET;
            emr2     <= 13'h0000;
            emr3     <= 13'h0000;
        end else begin
            // Start clears as the sequence begins, even if a mode word is written then.
            if (wr_en && pready && paddr == ADDR_CTRL) begin
                start    <= pwdata[CTRL_START_BIT];
                skip_rst <= pwdata[CTRL_SKIPRST_BIT];
            end else if (go) begin
                start <= 1'b0;
            end
            if (wr_en && pready && paddr == ADDR_MR) begin
                mr <= pwdata[12:0];
            end else if (wr_en && pready && paddr == ADDR_EMR1) begin
                emr1 <= pwdata[12:0];
            end else if (wr_en && pready && paddr == ADDR_EMR2) begin
                emr2 <= pwdata[12:0];
            end else if (wr_en && pready && paddr == ADDR_EMR3) begin
                emr3 <= pwdata[12:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequence next state; each step's delay is loaded into cnt.
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:    if (go) next_state = S_PWR;
            S_PWR:     if (wait_done) next_state = S_CKEW;
            S_CKEW:    if (wait_done) next_state = S_PRE1;
            S_PRE1:    if (wait_done) next_state = S_EMR2;
            S_EMR2:    if (wait_done) next_state = S_EMR3;
            S_EMR3:    if (wait_done) next_state = S_EMR1;
            S_EMR1:    if (wait_done) next_state = skip_rst ? S_PRE2 : S_MRRST;
            S_MRRST:   if (wait_done) next_state = S_PRE2;
            S_PRE2:    if (wait_done) next_state = S_REF;
            S_REF:     if (wait_done && refs == 2'(MIN_REFRESH - 1)) next_state = S_MR;
            S_MR:      if (wait_done) next_state = S_DLLW;
            S_DLLW:    if (wait_done) next_state = S_OCDDEF;
            S_OCDDEF:  if (wait_done) next_state = S_OCDEXIT;
            S_OCDEXIT: if (wait_done) next_state = S_READY;
            default:   next_state = state;
        endcase
    end

    // Link drive: commands last one cycle, then NOP until the delay ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            cnt   <= 32'h0;
            refs  <= 2'h0;
            link.cke   <= 1'b0;
            link.odt   <= 1'b0;
            link.dm    <= 1'b0;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            link.ba    <= 2'h0;
            link.addr  <= 13'h0000;
        end else begin
            state <= next_state;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
            if (next_state != state) begin
                cnt <= 32'h0;
                case (next_state)
                    S_PWR:  cnt <= 32'(POWERUP_CYCLES - 1);
                    S_CKEW: begin
                        // Cke rises once and never falls again, so no power-down or
                        // self refresh can start while a bank or an operation is busy.
                        link.cke <= 1'b1;
                        cnt <= 32'(CKEWAIT_CYC - 1);
                    end
                    S_PRE1, S_PRE2: begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
                        link.addr <= 13'h0400;                   // All-bank precharge.
                        cnt <= 32'(RP_CYC - 1);
                    end
                    S_EMR2, S_EMR3, S_EMR1, S_MRRST, S_MR, S_OCDDEF, S_OCDEXIT: begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                        cnt <= 32'(MRD_CYC - 1);
                        link.ba <= next_state == S_EMR2 ? BA_EMR2 :
                                   next_state == S_EMR3 ? BA_EMR3 :
                                   (next_state == S_MRRST || next_state == S_MR) ? BA_MR :
                                   BA_EMR1;
                        link.addr <=
                            next_state == S_EMR2 ? emr2 :
                            next_state == S_EMR3 ? emr3 :
                            next_state == S_MRRST ? (mr | 13'h0100) :
                            next_state == S_MR ? (mr & ~13'h0100) :
                            next_state == S_OCDDEF ? ((emr1 & ~13'h0381) | 13'h0380) :
                            next_state == S_OCDEXIT ? (emr1 & ~13'h0381) :
                            (emr1 & ~13'h0381);
                    end
                    S_REF: begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                        refs <= 2'h0;
                        cnt  <= 32'(RFC_CYC - 1);
                    end
                    S_DLLW: cnt <= 32'(DLL_LOCK_CYC - 1);
                    default: cnt <= 32'h0;
                endcase
            end else if (state == S_REF && wait_done) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                refs <= refs + 2'h1;
                cnt  <= 32'(RFC_CYC - 1);
            end else if (!wait_done) begin
                cnt <= cnt - 32'h1;
            end
        end
    end
endmodule : mrs_ctrl
`default_nettype wire

// [sim/ddr2_init_mode_register_monitor.sv]
// Checker of the controller-to-device command link during initialisation.
`timescale 1ns/1ps
`default_nettype none
module ddr2_init_mode_register_monitor
    import mrs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [12:0] addr,
    input wire logic        odt,
    input wire logic        dm
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Command decode shared by the properties below.
    wire [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
    wire       is_mrs = cke && (cmd == CMD_MRS);
    wire       is_ref = cke && (cmd == CMD_REF);
    wire       is_pre = cke && (cmd == CMD_PRE);
    wire       idle   = cmd[3] || (cmd == CMD_NOP);
    wire       ocd_on = is_mrs && ba == BA_EMR1 && addr[9:7] == 3'h7;
    wire       ocd_ex = is_mrs && ba == BA_EMR1 && addr[9:7] == 3'h0;
    wire       dll_ev = (is_mrs && ba == BA_MR && addr[8]) || (ocd_ex && !addr[0]);
    logic [6:0] cke_cnt;
    logic [8:0] dll_cnt;
    logic [1:0] mrs_n;
    logic       pre_seen;
    // Cycles since CKE rose, cycles since the last DLL event, and mode-set count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke_cnt  <= '0;
            dll_cnt  <= '0;
            mrs_n    <= '0;
            pre_seen <= 1'b0;
        end else begin
            cke_cnt  <= !cke ? 7'h0 : cke_cnt + 7'(cke_cnt != 7'h7f);
            dll_cnt  <= dll_ev ? 9'h0 : dll_cnt + 9'(dll_cnt != 9'h1ff);
            mrs_n    <= mrs_n + 2'(is_mrs && mrs_n != 2'h3);
            pre_seen <= pre_seen || is_pre;
        end
    end
    a_cke_min_high: assert property ($rose(cke) |=> cke[*8]) else $error("cke pulse short");
    a_odt_low_init: assert property (!cke |-> !odt) else $error("odt high with cke low");
    a_cke_no_fall: assert property (!$fell(cke)) else $error("cke fell after rising");
    a_nop_wait: assert property ((cke && cke_cnt < CKEWAIT_CYC) |-> idle)
        else $error("command inside cke wait");
    a_pre_first: assert property ((cke && !idle && !pre_seen) |-> cmd == CMD_PRE)
        else $error("first command not precharge");
    a_emr2_first: assert property ((is_mrs && mrs_n == 2'h0) |-> ba == BA_EMR2)
        else $error("first mode set not emr2");
    a_emr3_next: assert property ((is_mrs && mrs_n == 2'h1) |-> ba == BA_EMR3)
        else $error("second mode set not emr3");
    a_dll_enable: assert property ((is_mrs && mrs_n == 2'h2) |-> ba == BA_EMR1 && !addr[0])
        else $error("third mode set not dll enable");
    a_dllrst_pre: assert property ((is_mrs && ba == BA_MR && addr[8]) |-> ##[1:8] is_pre)
        else $error("no precharge after dll reset");
    a_ref_spacing: assert property (is_ref |=> !is_ref[*8]) else $error("refresh too close");
    a_ocd_wait: assert property (ocd_on |-> dll_cnt >= 9'(DLL_LOCK_CYC - 1))
        else $error("calibration too early");
    a_ocd_exit: assert property (ocd_on |-> ##[1:8] ocd_ex) else $error("no calibration exit");
    c_refresh: cover property (is_ref);
    c_dll_reset: cover property (is_mrs && ba == BA_MR && addr[8]);
    c_ocd_exit: cover property (ocd_ex && pre_seen);
endmodule // ddr2_init_mode_register_monitor
`default_nettype wire

// [sim/ddr2_init_mode_register_test.sv]
// Bench joining controller and device, checking init results and burst order.
`timescale 1ns/1ps
`default_nettype none
module ddr2_init_mode_register_test;
    import mrs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, locked, cfg_err, cv, cv1;
    logic        pd, sr, bm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] mr, e1, e2, e3, x_mr, x_e1, x_e2;
    logic [2:0]  bs, bi, col, ts, tb;
    logic [33:0] q_apb[$];
    logic [2:0]  q_col[$];
    logic [33:0] ea;
    int          n_fail, cmp_count, r, i, n;
    mrs_link_if link();
    mrs_ctrl #(.POWERUP_CYCLES(10)) i_mrs_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    mrs_device i_mrs_device (.pclk(pclk), .presetn(presetn), .link(link), .burst_start(bs),
        .beat_index(bi), .mr(mr), .emr1(e1), .emr2(e2), .emr3(e3), .burst_col(col),
        .powered_down(pd), .self_refresh(sr), .dll_locked(locked), .cfg_error(cfg_err),
        .beat_masked(bm));
    ddr2_init_mode_register_monitor i_mon (.pclk(pclk), .presetn(presetn), .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .odt(link.odt), .dm(link.dm));
    // Clock of 10 ns period.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; its expected answer {compare data, error, data} is queued.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        int k;
        q_apb.push_back(e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 20) begin
            n_fail++;
            test_done();
        end
    endtask
    // Column expected for a start address and beat in either burst type.
    function automatic logic [2:0] col_of(logic bl8, logic bt, logic [2:0] s, logic [2:0] b);
        return {s[2] ^ (bl8 & b[2]), bt ? s[1:0] ^ b[1:0] : s[1:0] + b[1:0]};
    endfunction
    // Watcher: takes the oldest note whenever a transfer ends or a column is due.
    always @(posedge pclk) begin
        cv1 <= cv;
        if (cv1) check("burst_col", 32'(col), 32'(q_col.pop_front()));
        if (psel && penable && pready === 1'b1) begin
            ea = q_apb.pop_front();
            check("pslverr", 32'(pslverr), 32'(ea[32]));
            if (ea[33]) check("prdata", prdata, ea[31:0]);
        end
    end
    // Four rounds cover both burst lengths, both burst types and the skip bit.
    initial begin
        {presetn, psel, penable, pwrite, cv, paddr, pwdata, bs, bi} = '0;
        n_fail = 0;
        cmp_count = 0;
        void'($urandom(47271));
        for (r = 0; r < 4; r++) begin
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            apb(1'b0, ADDR_MR, 32'h0, {2'b10, 19'h0, MR_RESET});
            apb(1'b0, ADDR_EMR1, 32'h0, {2'b10, 19'h0, EMR1_RESET});
            apb(1'b1, 12'h020, $urandom, 34'h1_0000_0000);
            apb(1'b0, 12'h020, 32'h0, 34'h3_0000_0000);
            x_mr = {1'b0, 3'($urandom_range(1, 5)), 2'b0, 3'($urandom_range(3, 6)), r[1],
                    r[0] ? BL_CODE8 : BL_CODE4};
            x_e1 = 13'($urandom) & 13'h047e;
            x_e2 = 13'($urandom) & 13'h0088;
            apb(1'b1, ADDR_MR, 32'(x_mr), 34'h0);
            apb(1'b1, ADDR_EMR1, 32'(x_e1), 34'h0);
            apb(1'b1, ADDR_EMR2, 32'(x_e2), 34'h0);
            apb(1'b1, ADDR_EMR3, 32'h0, 34'h0);
            apb(1'b0, ADDR_MR, 32'h0, {2'b10, 19'h0, x_mr});
            apb(1'b1, ADDR_CTRL, {30'h0, r[0] ^ r[1], 1'b1}, 34'h0);
            n = 0;
            do begin
                apb(1'b0, ADDR_STATUS, 32'h0, 34'h0);
                n++;
            end while (rd !== 32'd14 && n < 500);
            if (n >= 500) begin
                n_fail++;
                test_done();
            end
            apb(1'b0, ADDR_STATUS, 32'h0, {2'b10, 32'd14});
            check("mr", 32'(mr), 32'(x_mr));
            check("emr1", 32'(e1), 32'(x_e1));
            check("emr2", 32'(e2), 32'(x_e2));
            check("emr3", 32'(e3), 32'h0);
            check("cfg_error", 32'(cfg_err), 32'h0);
            check("powered_down", 32'(pd), 32'h0);
            check("self_refresh", 32'(sr), 32'h0);
            check("beat_masked", 32'(bm), 32'h0);
            for (i = 0; i < 16; i++) begin
                ts = 3'($urandom);
                tb = r[0] ? 3'($urandom) : 3'($urandom_range(0, 3));
                bs <= ts;
                bi <= tb;
                cv <= 1'b1;
                q_col.push_back(col_of(r[0], r[1], ts, tb));
                @(posedge pclk);
            end
            cv <= 1'b0;
            repeat (DLL_LOCK_CYC + 2) @(posedge pclk);
            check("dll_locked", 32'(locked), 32'h1);
        end
        test_done();
    end
endmodule // ddr2_init_mode_register_test
`default_nettype wire
